// *** verilog/ddr3_init_pkg.sv ***
// Constants, types and helpers for the DDR3 init and mode load block.
// Assumes a 100 MHz device clock and a 32-bit AHB-Lite register port.
package ddr3_init_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_US     = 500;
  localparam int SETTLE_CYCLES = (SETTLE_US * 1000 + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int XS_NS         = 120;
  localparam int XPR_MIN_TCK   = 5;
  localparam int XS_CYCLES     = (XS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int XPR_CYCLES    = (XS_CYCLES > XPR_MIN_TCK) ? XS_CYCLES
                                                           : XPR_MIN_TCK;
  localparam int MRD_CYCLES    = 4;
  localparam int MOD_CYCLES    = 12;
  localparam int DLLK_CYCLES   = 512;
  localparam int ZQINIT_CYCLES = 512;
  localparam int TIMER_W       = 16;

  localparam int ADDR_W = 13;
  localparam int BA_W   = 3;
  localparam int ERR_W  = 6;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_ERROR   = 8'h08;
  localparam logic [7:0] OFS_LATENCY = 8'h0c;
  localparam logic [7:0] OFS_MODE0   = 8'h10;
  localparam logic [7:0] OFS_MODE3   = 8'h1c;

  // Mode word field positions
  localparam int MR0_CL_LOW_BIT  = 2;
  localparam int MR0_CL_FIELD_LO = 4;
  localparam int MR0_CL_FIELD_HI = 6;
  localparam int MR0_TEST_BIT    = 7;
  localparam int MR0_DLL_RST_BIT = 8;
  localparam int MR1_AL_LO       = 3;
  localparam int MR1_AL_HI       = 4;
  localparam int ZQ_LONG_BIT     = 10;
  localparam logic [4:0] CL_BASE      = 5'h04;
  localparam logic [4:0] CL_HIGH_STEP = 5'h08;

  localparam logic [BA_W-1:0] BA_MR0 = 3'h0;
  localparam logic [BA_W-1:0] BA_MR1 = 3'h1;

  // Error flag positions
  localparam int ERR_EARLY_MRS = 0;
  localparam int ERR_MRD       = 1;
  localparam int ERR_MOD       = 2;
  localparam int ERR_TEST_MODE = 3;
  localparam int ERR_CKE_DROP  = 4;
  localparam int ERR_EARLY_RD  = 5;

  typedef enum logic [2:0] {
    ST_RESET, ST_SETTLE, ST_WAIT_CKE, ST_EXIT, ST_CONFIG, ST_READY
  } init_state_t;

  function automatic logic [4:0] cl_decode(input logic [ADDR_W-1:0] a);
    logic [4:0] cl;
    cl = CL_BASE + {2'h0, a[MR0_CL_FIELD_HI:MR0_CL_FIELD_LO]};
    if (a[MR0_CL_LOW_BIT]) begin
      cl = cl + CL_HIGH_STEP;
    end
    return cl;
  endfunction

  // Added delay: code 1 gives CL-1, code 2 gives CL-2, others none
  function automatic logic [4:0] al_decode(input logic [1:0] code,
                                           input logic [4:0] cl);
    logic [4:0] al;
    al = 5'h00;
    if (code == 2'h1) begin
      al = cl - 5'h01;
    end else if (code == 2'h2) begin
      al = cl - 5'h02;
    end
    return al;
  endfunction
endpackage

// *** verilog/mode_store.sv ***
// Storage for the four mode words, read data registered.
// Assumes one writer and one reader on the same clock.
`timescale 1ns/100ps
module mode_store
  import ddr3_init_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              wr_en,
  input  wire logic [1:0]        wr_idx,
  input  wire logic [ADDR_W-1:0] wr_data,
  input  wire logic [1:0]        rd_idx,
  output logic      [ADDR_W-1:0] rd_data
);
  // No reset: mode words hold no defined value until written
  logic [ADDR_W-1:0] mem [4];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
  end
endmodule

// *** verilog/ddr3_init_mode_load.sv ***
// Device-side power-up, reset and mode word load logic of a DDR3 part.
// Command pins arrive from the controller and are synchronised first;
// software watches progress and errors over AHB-Lite.
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// Notes on behaviour
// (R1) Controller holds reset pin low at least 200us after power is stable.
// (R2) Controller drives clock gate low 10ns before releasing reset.
// (R3) Device initialises internally for 500us after reset release.
// (R4) Controller runs stable clock max(10ns,5tCK) before clock gate rises.
// (R5) NOP or deselect is registered before clock gate first rises.
// (R6) Clock gate stays high until initialisation completes.
// (R7) Termination stays off during reset until clock gate registered high.
// (R8) Termination control held static during init; low if nominal used.
// (R9) First mode write waits reset_cke_exit_delay after clock gate high.
// (R10) Mode words load in order 2, 3, 1, 0 by bank select.
// (R11) Word 1 enables delay loop; word 0 resets it via A8.
// (R12) Long calibration follows word 0; wait lock and calibration times.
// (R13) Warm reset: pin low 100ns, then repeat from the 500us wait.
// (R14) Mode words undefined after reset; all must be written.
// (R15) Every mode write supplies all fields of the word.
// (R16) Consecutive mode writes spaced by mode_write_cycle_time.
// (R17) Other commands wait mode_update_delay after a mode write.
// (R18) Rewrites only when idle, precharged and clock gate high.
// (R19) Word 0 write: all command strobes and bank bits low.
// (R20) Reserved mode bits written as zero.
// (R21) Write recovery field at least write recovery over clock period.
// (R22) Column latency from A2, A4-A6; read latency is sum with added.
// (R23) A7 set selects test mode; must stay zero.
// (R24) Delay-loop reset bit self-clears; reads wait the lock time.
// (R25) Controller rounds waits up to whole clock cycles.
module ddr3_init_mode_load
  import ddr3_init_pkg::*;
#(
  parameter logic [TIMER_W-1:0] SETTLE_LEN = TIMER_W'(SETTLE_CYCLES)
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              reset_pin_n,
  input  wire logic              cke,
  input  wire logic              cs_n,
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic [BA_W-1:0]   ba,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              termination_control,
  output logic                   rtt_enable,
  output logic                   device_ready
);
  localparam int PIN_W = 7 + BA_W + ADDR_W;

  logic [PIN_W-1:0]  sync1_r, sync2_r;
  logic              rst_pin_s, cke_s, cs_s, ras_s, cas_s, we_s, odt_s;
  logic [BA_W-1:0]   ba_s;
  logic [ADDR_W-1:0] a_s;

  // Pins come from the controller's launch clock; two stages each
  always_ff @(posedge clk) begin
    sync1_r <= {reset_pin_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
                termination_control};
    sync2_r <= sync1_r;
  end
  assign {rst_pin_s, cke_s, cs_s, ras_s, cas_s, we_s, ba_s, a_s, odt_s}
    = sync2_r;

  logic cmd_mrs, cmd_long_impedance_calibration, cmd_read, cmd_other;
  assign cmd_mrs   = cke_s && !cs_s && !ras_s && !cas_s && !we_s;
  assign cmd_long_impedance_calibration  = cke_s && !cs_s && ras_s && cas_s && !we_s
                     && a_s[ZQ_LONG_BIT];
  assign cmd_read  = cke_s && !cs_s && ras_s && !cas_s && we_s;
  assign cmd_other = cke_s && !cs_s && !(ras_s && cas_s && we_s) && !cmd_mrs;

  // Init sequence state
  init_state_t          state_r, state_nxt;
  logic [TIMER_W-1:0]   timer_r, timer_nxt;
  logic [3:0]           written_r, written_nxt;
  logic [TIMER_W-1:0]   since_mrs_r, since_mrs_nxt;
  logic [TIMER_W-1:0]   dll_cnt_r, dll_cnt_nxt;
  logic [TIMER_W-1:0]   zq_cnt_r, zq_cnt_nxt;
  logic                 dll_lock_r, dll_lock_nxt;
  logic                 zq_done_r, zq_done_nxt;
  logic [4:0]           cl_r, cl_nxt;
  logic [1:0]           al_code_r, al_code_nxt;
  logic [ERR_W-1:0]     err_r, err_nxt, err_set, err_clr;
  logic                 rtt_nxt, ready_nxt;
  logic                 mrs_ok;
  logic [ADDR_W-1:0]    store_data;

  assign mrs_ok = cmd_mrs && !ba_s[BA_W-1]
                  && (state_r == ST_CONFIG || state_r == ST_READY);

  always_comb begin
    state_nxt     = state_r;
    timer_nxt     = timer_r;
    written_nxt   = written_r;
    since_mrs_nxt = since_mrs_r;
    dll_cnt_nxt   = dll_cnt_r;
    zq_cnt_nxt    = zq_cnt_r;
    dll_lock_nxt  = dll_lock_r;
    zq_done_nxt   = zq_done_r;
    cl_nxt        = cl_r;
    al_code_nxt   = al_code_r;
    err_set       = '0;
    store_data    = a_s;
    if (since_mrs_r < TIMER_W'(MOD_CYCLES)) begin
      since_mrs_nxt = since_mrs_r + 1'b1;
    end
    if (dll_cnt_r != '0) begin
      dll_cnt_nxt = dll_cnt_r - 1'b1;
      dll_lock_nxt = (dll_cnt_r == TIMER_W'(1));
    end
    if (zq_cnt_r != '0) begin
      zq_cnt_nxt = zq_cnt_r - 1'b1;
      zq_done_nxt = (zq_cnt_r == TIMER_W'(1));
    end
    // Checks on controller behaviour, kept as sticky flags
    if (cmd_mrs && (state_r == ST_EXIT || state_r == ST_WAIT_CKE)) begin
      err_set[ERR_EARLY_MRS] = 1'b1; // R9
    end
    if (mrs_ok && since_mrs_r < TIMER_W'(MRD_CYCLES)) begin
      err_set[ERR_MRD] = 1'b1; // R16
    end
    if (cmd_other && since_mrs_r < TIMER_W'(MOD_CYCLES)) begin
      err_set[ERR_MOD] = 1'b1; // R17
    end
    if (mrs_ok && ba_s == BA_MR0 && a_s[MR0_TEST_BIT]) begin
      err_set[ERR_TEST_MODE] = 1'b1; // R23
    end
    if (!cke_s && (state_r == ST_EXIT || state_r == ST_CONFIG)) begin
      err_set[ERR_CKE_DROP] = 1'b1; // R6
    end
    if (cmd_read && !dll_lock_r) begin
      err_set[ERR_EARLY_RD] = 1'b1; // R24
    end
    if (mrs_ok) begin
      since_mrs_nxt = TIMER_W'(1);
      written_nxt[ba_s[1:0]] = 1'b1; // R14
      if (ba_s == BA_MR0) begin
        cl_nxt = cl_decode(a_s); // R22
        store_data[MR0_DLL_RST_BIT] = 1'b0; // R24
        if (a_s[MR0_DLL_RST_BIT]) begin
          dll_cnt_nxt  = TIMER_W'(DLLK_CYCLES);
          dll_lock_nxt = 1'b0;
        end
      end else if (ba_s == BA_MR1) begin
        al_code_nxt = a_s[MR1_AL_HI:MR1_AL_LO]; // R22
      end
    end
    if (cmd_long_impedance_calibration && state_r != ST_RESET) begin
      zq_cnt_nxt  = TIMER_W'(ZQINIT_CYCLES);
      zq_done_nxt = 1'b0;
    end
    unique case (state_r)
      ST_RESET: begin
        timer_nxt = '0;
        state_nxt = ST_SETTLE;
      end
      ST_SETTLE: begin
        timer_nxt = timer_r + 1'b1;
        if (timer_r == SETTLE_LEN - 1'b1) begin
          state_nxt = ST_WAIT_CKE; // R3
        end
      end
      ST_WAIT_CKE: begin
        timer_nxt = '0;
        if (cke_s) begin
          state_nxt = ST_EXIT;
        end
      end
      ST_EXIT: begin
        timer_nxt = timer_r + 1'b1;
        if (timer_r == TIMER_W'(XPR_CYCLES - 1)) begin
          state_nxt = ST_CONFIG;
        end
      end
      ST_CONFIG: begin
        if (written_r == 4'hf && dll_lock_r && zq_done_r) begin
          state_nxt = ST_READY; // R14
        end
      end
      ST_READY: begin
        state_nxt = ST_READY;
      end
    endcase
    // Pin reset restarts the init sequence, warm or cold; error flags and latencies are kept
    if (!rst_pin_s) begin
      state_nxt   = ST_RESET; // R13
      written_nxt = '0;
      dll_cnt_nxt = '0;
      zq_cnt_nxt  = '0;
      dll_lock_nxt = 1'b0;
      zq_done_nxt  = 1'b0;
      since_mrs_nxt = TIMER_W'(MOD_CYCLES);
    end
    // Set wins over a software clear in the same cycle
    err_nxt = (err_r & ~err_clr) | err_set;
    rtt_nxt = odt_s && !(state_r inside {ST_RESET, ST_SETTLE,
                                         ST_WAIT_CKE}); // R7
    ready_nxt = (state_nxt == ST_READY);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r      <= ST_RESET;
      timer_r      <= '0;
      written_r    <= '0;
      since_mrs_r  <= TIMER_W'(MOD_CYCLES);
      dll_cnt_r    <= '0;
      zq_cnt_r     <= '0;
      dll_lock_r   <= 1'b0;
      zq_done_r    <= 1'b0;
      cl_r         <= CL_BASE;
      al_code_r    <= '0;
      err_r        <= '0;
      rtt_enable   <= 1'b0;
      device_ready <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      timer_r      <= timer_nxt;
      written_r    <= written_nxt;
      since_mrs_r  <= since_mrs_nxt;
      dll_cnt_r    <= dll_cnt_nxt;
      zq_cnt_r     <= zq_cnt_nxt;
      dll_lock_r   <= dll_lock_nxt;
      zq_done_r    <= zq_done_nxt;
      cl_r         <= cl_nxt;
      al_code_r    <= al_code_nxt;
      err_r        <= err_nxt;
      rtt_enable   <= rtt_nxt;
      device_ready <= ready_nxt;
    end
  end

  // AHB-Lite slave: every transfer takes one wait state, since the
  // mode store answers a cycle after its address
  logic        pend_r, pend_nxt, wr_r, wr_nxt, accept;
  logic [7:0]  pa_r, pa_nxt;
  logic [31:0] rdata_nxt;
  logic        rdy_nxt;
  logic        hold_r, hold_nxt;
  logic [ADDR_W-1:0] mode_rd;
  logic [4:0]  rl;

  assign accept = hsel && htrans[1] && hready;
  assign rl     = al_decode(al_code_r, cl_r) + cl_r; // R22

  mode_store u_store (
    .clk     (clk),
    .wr_en   (mrs_ok),
    .wr_idx  (ba_s[1:0]),
    .wr_data (store_data),
    .rd_idx  (haddr[3:2]),
    .rd_data (mode_rd)
  );

  always_comb begin
    pend_nxt  = accept;
    wr_nxt    = hwrite;
    pa_nxt    = haddr[7:0];
    rdata_nxt = hrdata;
    rdy_nxt   = !accept;
    hold_nxt  = hold_r;
    err_clr   = '0;
    if (pend_r) begin
      rdata_nxt = '0;
      if (wr_r) begin
        if (pa_r == OFS_CONTROL) begin
          hold_nxt = hwdata[0];
        end else if (pa_r == OFS_ERROR) begin
          err_clr = hwdata[ERR_W-1:0];
        end
      end else if (pa_r == OFS_CONTROL) begin
        rdata_nxt = {31'h0, hold_r};
      end else if (pa_r == OFS_STATUS) begin
        rdata_nxt = {22'h0, dll_lock_r, zq_done_r, written_r,
                     3'(state_r), device_ready};
      end else if (pa_r == OFS_ERROR) begin
        rdata_nxt = {{(32 - ERR_W){1'b0}}, err_r};
      end else if (pa_r == OFS_LATENCY) begin
        rdata_nxt = {17'h0, rl, al_decode(al_code_r, cl_r), cl_r};
      end else if (pa_r >= OFS_MODE0 && pa_r <= OFS_MODE3) begin
        rdata_nxt = {{(32 - ADDR_W){1'b0}}, mode_rd};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pend_r    <= 1'b0;
      wr_r      <= 1'b0;
      pa_r      <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hold_r    <= 1'b0;
    end else begin
      pend_r    <= pend_nxt;
      wr_r      <= wr_nxt;
      pa_r      <= pa_nxt;
      hrdata    <= rdata_nxt;
      hreadyout <= rdy_nxt;
      hresp     <= 1'b0;
      hold_r    <= hold_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_settle_length: assert property ( // R3
    ($past(state_r) == ST_SETTLE && state_r == ST_WAIT_CKE && rst_pin_s)
      |-> $past(timer_r) == SETTLE_LEN - 1'b1)
    else $error("settle wait ended at wrong count");
  a_rtt_off_early: assert property ( // R7
    (state_r inside {ST_RESET, ST_SETTLE, ST_WAIT_CKE}) |=> !rtt_enable)
    else $error("termination on before clock gate registered");
  a_ready_all_words: assert property ( // R14
    device_ready |-> written_r == 4'hf && dll_lock_r && zq_done_r)
    else $error("ready without all mode words and lock");
  a_cl_captured: assert property ( // R22
    (mrs_ok && ba_s == BA_MR0 && rst_pin_s) |=> cl_r == cl_decode($past(a_s)))
    else $error("column latency not taken from mode word 0");
  a_dll_lock_wait: assert property ( // R24
    (mrs_ok && ba_s == BA_MR0 && a_s[MR0_DLL_RST_BIT]) |=> !dll_lock_r[*8])
    else $error("delay loop locked too soon");
  a_dll_bit_clear: assert property ( // R24
    (mrs_ok && ba_s == BA_MR0) |-> !store_data[MR0_DLL_RST_BIT])
    else $error("delay loop reset bit stored");
  a_ahb_one_wait: assert property (
    accept |=> !hreadyout ##1 hreadyout)
    else $error("bus answer not after one wait state");
  a_err_sticky: assert property (
    (err_set != '0) |=> (err_r & $past(err_set)) == $past(err_set))
    else $error("error flag lost");

  c_ready: cover property ($rose(device_ready));
  c_dll_reset: cover property (mrs_ok && a_s[MR0_DLL_RST_BIT]);
  c_warm_reset: cover property (state_r == ST_READY ##1 !rst_pin_s);
  c_error: cover property (err_r != '0);
endmodule

// *** tb/ctrl_model.sv ***
// Memory controller side model driving reset, clock gate and command pins.
// Assumes the bench calls its tasks; pins change just after rising edges.
`timescale 1ns/100ps
module ctrl_model
  import ddr3_init_pkg::*;
(
  input  wire logic    clk,
  output logic         reset_pin_n,
  output logic         cke,
  output logic         cs_n,
  output logic         ras_n,
  output logic         cas_n,
  output logic         we_n,
  output logic [2:0]   ba,
  output logic [12:0]  addr,
  output logic         termination_control
);
  initial begin
    reset_pin_n = 1'b0;
    cke = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    ba = 3'h0;
    addr = 13'h0000;
    // Nominal termination left off in word 1, so high is legal
    termination_control = 1'b1;
  end
  // One command cycle, then NOP; address scrambled so stale bits show
  task automatic cmd(input logic [3:0] c, input logic [2:0] b,
                     input logic [12:0] a);
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= c;
    ba <= b;
    addr <= a;
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= 4'h7;
    addr <= ~a;
  endtask
  // Clock gate moves one cycle ahead of the reset pin
  task automatic pin(input logic r, input logic k);
    @(posedge clk);
    cke <= k;
    @(posedge clk);
    reset_pin_n <= r;
  endtask
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the init and mode load block.
// Assumes a shortened settle count; expectations come from local model.
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  failures++; $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); \
  end end
module tb_top;
  logic        clk, reset, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, ba;
  logic [12:0] addr, mw [4];
  logic        reset_pin_n, cke, cs_n, ras_n, cas_n, we_n;
  logic        termination_control, rtt_enable, device_ready;
  logic [4:0]  cl, al;
  int          failures, checks_done, cyc, code, i;
  integer      seed;

  assign hready = hreadyout;
  ctrl_model ctl (.clk(clk), .reset_pin_n(reset_pin_n), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
    .addr(addr), .termination_control(termination_control));
  ddr3_init_mode_load #(.SETTLE_LEN(16'h0014)) DUT (.clk(clk),
    .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .reset_pin_n(reset_pin_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
    .termination_control(termination_control), .rtt_enable(rtt_enable),
    .device_ready(device_ready));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Run is under a thousand cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, rd);
    `CHK(rd, e)
    `CHK(hresp, 1'b0)
  endtask

  task automatic mode_register_write(input logic [2:0] b, input logic [12:0] v);
    ctl.cmd(4'h0, b, v);
    repeat (4) @(posedge clk);
  endtask

  initial begin
    seed = 32'ha6da;
    {reset, hsel, hwrite, htrans, haddr, hwdata} = {3'h4, 66'h0};
    hsize = 3'h2;
    {failures, checks_done, cyc} = {32'h0, 32'h0, 32'h0};
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rdchk(8'h04, 32'h0);
    rdchk(8'h08, 32'h0);
    ahb(1'b1, 8'h00, 32'h1, rd);
    rdchk(8'h00, 32'h1);
    ahb(1'b1, 8'h40, 32'hffffffff, rd);
    rdchk(8'h40, 32'h0);
    ctl.pin(1'b1, 1'b0);
    repeat (5) @(posedge clk);
    rdchk(8'h04, 32'h2);
    repeat (30) @(posedge clk);
    rdchk(8'h04, 32'h4);
    `CHK(rtt_enable, 1'b0)
    ctl.pin(1'b1, 1'b1);
    repeat (2) @(posedge clk);
    ctl.cmd(4'h0, 3'h2, 13'h0000);
    repeat (20) @(posedge clk);
    rdchk(8'h04, 32'h8);
    rdchk(8'h08, 32'h1);
    ahb(1'b1, 8'h08, 32'h1, rd);
    rdchk(8'h08, 32'h0);
    code = {$random(seed)} % 3;
    mw[2] = 13'($random(seed)) & 13'h0638;
    mw[3] = 13'($random(seed)) & 13'h0003;
    mw[1] = (13'($random(seed)) & 13'h1822) | 13'(code << 3);
    mw[0] = (13'($random(seed)) & 13'h1e77) | 13'h0100;
    mw[0] = mw[0] | 13'h0200;
    cl = 5'h04 + {2'h0, mw[0][6:4]} + {1'b0, mw[0][2], 3'h0};
    al = (code == 1) ? cl - 5'h01 : (code == 2) ? cl - 5'h02 : 5'h00;
    ctl.cmd(4'h0, 3'h2, mw[2]);
    mode_register_write(3'h2, mw[2]);
    rdchk(8'h04, 32'h48);
    mode_register_write(3'h3, mw[3]);
    mode_register_write(3'h1, mw[1]);
    ctl.cmd(4'h0, 3'h0, mw[0] | 13'h0080);
    ctl.cmd(4'h1, 3'h0, 13'h0000);
    repeat (14) @(posedge clk);
    mode_register_write(3'h0, mw[0]);
    repeat (10) @(posedge clk);
    ctl.cmd(4'h6, 3'h0, 13'h0400);
    ctl.cmd(4'h5, 3'h0, 13'h0000);
    repeat (6) @(posedge clk);
    rdchk(8'h08, 32'h2e);
    rdchk(8'h04, 32'hf8);
    for (i = 0; i < 4; i++) begin
      rdchk(8'(8'h10 + 4 * i), {19'h0, mw[i] & ((i == 0) ? 13'h1eff
                                                 : 13'h1fff)});
    end
    rdchk(8'h0c, {17'h0, al + cl, al, cl});
    repeat (600) @(posedge clk);
    rdchk(8'h04, 32'h3fb);
    `CHK(device_ready, 1'b1)
    mw[2] = 13'($random(seed)) & 13'h0638;
    mode_register_write(3'h2, mw[2]);
    rdchk(8'h18, {19'h0, mw[2]});
    rdchk(8'h04, 32'h3fb);
    ctl.pin(1'b0, 1'b0);
    repeat (12) @(posedge clk);
    rdchk(8'h04, 32'h0);
    `CHK(device_ready, 1'b0)
    ctl.pin(1'b1, 1'b0);
    repeat (5) @(posedge clk);
    rdchk(8'h04, 32'h2);
    tally_and_finish();
  end
endmodule
